//--- core/interval_elapsed_timer.sv
// Interval and elapsed timer on the host I/O channel
`include "rtc_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module interval_elapsed_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  input  wire rtc_pkg::host_req_t REQ,
  input  wire logic [3:0]        EQUIP_SEL,
  input  wire logic [2:0]        RATE_SEL,
  output var  rtc_pkg::host_ans_t ANS,
  output var  logic              INTERVAL_IRQ_LINE
);
  import rtc_pkg::*;

  // Period of one 1 us tick in REF_CLK cycles, via the 20 MHz base
  localparam int OSC_DIV  = `CLK_MHZ / `OSC_MHZ;
  localparam int US_CYC   = OSC_DIV * `OSC_MHZ * `TICK_BASE_NS / 1000;

  initial begin
    if (WIDTH != 16) $error("WIDTH must be 16");
    if (OSC_DIV < 1) $error("REF_CLK slower than oscillator");
  end

  function automatic logic [31:0] decades(input logic [2:0] sel);
    logic [31:0] d;
    d = 32'h0000_0001;
    for (int i = 0; i < `RATE_COUNT - 1; i++) begin
      if (32'(i) < 32'(sel)) d = d * 32'd10;
    end
    return d;
  endfunction

  // Jumper and host inputs come from another domain: two flops
  host_req_t  req_m_q, req_s_q, req_p_q;
  logic [3:0] eq_m_q, eq_s_q;
  logic [2:0] rate_m_q, rate_s_q;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      req_m_q  <= '0;
      req_s_q  <= '0;
      req_p_q  <= '0;
      eq_m_q   <= '0;
      eq_s_q   <= '0;
      rate_m_q <= `SEL_ZERO;
      rate_s_q <= `SEL_ZERO;
    end else begin
      req_m_q  <= REQ;
      req_s_q  <= req_m_q;
      req_p_q  <= req_s_q;
      eq_m_q   <= EQUIP_SEL;
      eq_s_q   <= eq_m_q;
      rate_m_q <= RATE_SEL;
      rate_s_q <= rate_m_q;
    end
  end

  // A request is taken on the rising edge of read or write
  logic rd_ev, wr_ev;
  assign rd_ev = req_s_q.read  & ~req_p_q.read;
  assign wr_ev = req_s_q.write & ~req_p_q.write;

  logic [WIDTH-1:0] hold_q, hold_d, cnt_q, cnt_d, obuf_q, obuf_d;
  logic [31:0]      pre_q, pre_d;
  logic             run_q, run_d, ien_q, ien_d, irq_q, irq_d;
  logic             hit;
  host_ans_t        ans_q, ans_d;

  logic        addr_ok, w_ok, dir, rej_ext, tick;
  logic [15:0] fn;
  logic [WIDTH-1:0] cnt_inc;
  logic [31:0] period;

  always_comb begin
    w_ok    = req_s_q.addr[`ADDR_W_MSB:`ADDR_W_LSB] == '0;
    addr_ok = req_s_q.addr[`ADDR_EQ_MSB:`ADDR_EQ_LSB] == eq_s_q;
    // Bits 1 to 6 of the address never enter the decode
    dir     = req_s_q.addr[`ADDR_DIR_BIT];
    fn      = req_s_q.data;
    // Only bits 0,1,6,7,14,15 are examined
    rej_ext = 1'b0;
    if (rd_ev && !dir) rej_ext = 1'b1;
    if (wr_ev && dir) begin
      if (fn[`FN_STOP_BIT] && fn[`FN_START_BIT]) rej_ext = 1'b1;
      if (fn[`FN_IDIS_BIT] && fn[`FN_IEN_BIT]) rej_ext = 1'b1;
      // Clear runs first, so ack after clear has nothing to drop
      if (fn[`FN_ACK_BIT] && (!irq_q || fn[`FN_CLEAR_BIT]))
        rej_ext = 1'b1;
    end
  end

  always_comb begin
    period = 32'(US_CYC) * decades(rate_s_q);
    hold_d = hold_q;
    cnt_d  = cnt_q;
    obuf_d = obuf_q;
    pre_d  = pre_q;
    run_d  = run_q;
    ien_d  = ien_q;
    irq_d  = irq_q;
    ans_d  = '0;
    tick   = 1'b0;
    hit    = 1'b0;
    cnt_inc = cnt_q + 1'b1;

    if (run_q) begin
      if (pre_q >= period - 32'd1) begin
        pre_d = '0;
        tick  = 1'b1;
      end else begin
        pre_d = pre_q + 32'd1;
      end
    end
    if (tick) begin
      // Zero in the holding register matches after the wrap
      if (ien_q && cnt_inc == hold_q) begin
        irq_d = 1'b1;
        hit   = 1'b1;
        cnt_d = '0;
      end else begin
        cnt_d = cnt_inc;
      end
    end

    if (rd_ev || wr_ev) begin
      ans_d.reply = 1'b1;
      if (!w_ok || !addr_ok) begin
        ans_d.int_reject = 1'b1;
      end else if (rej_ext) begin
        ans_d.ext_reject = 1'b1;
      end else if (rd_ev) begin
        obuf_d     = cnt_q;
        ans_d.data = cnt_q;
      end else if (!dir) begin
        hold_d = fn;
        cnt_d  = '0;
      end else begin
        if (fn[`FN_CLEAR_BIT]) begin
          hold_d = `WORD_ZERO;
          cnt_d  = `WORD_ZERO;
          obuf_d = `WORD_ZERO;
          pre_d  = '0;
          run_d  = 1'b0;
          ien_d  = 1'b0;
          irq_d  = 1'b0;
        end
        if (fn[`FN_ACK_BIT]) irq_d = 1'b0;
        if (fn[`FN_STOP_BIT]) begin
          run_d = 1'b0;
          if (!fn[`FN_CLEAR_BIT]) cnt_d = cnt_q;
        end
        if (fn[`FN_START_BIT]) begin
          pre_d = '0;
          cnt_d = `WORD_ZERO;
          run_d = 1'b1;
        end
        if (fn[`FN_IDIS_BIT]) begin
          ien_d = 1'b0;
          irq_d = 1'b0;
        end
        if (fn[`FN_IEN_BIT]) ien_d = 1'b1;
      end
    end
    // A match in the ack cycle must not be lost: set wins
    if (hit && ien_d) irq_d = 1'b1;
    // Read-back data always shows the output buffer
    ans_d.data = obuf_d;
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      // Master clear state
      hold_q <= `WORD_ZERO;
      cnt_q  <= `WORD_ZERO;
      obuf_q <= `WORD_ZERO;
      pre_q  <= '0;
      run_q  <= 1'b0;
      ien_q  <= 1'b0;
      irq_q  <= 1'b0;
      ans_q  <= '0;
      INTERVAL_IRQ_LINE <= 1'b0;
    end else begin
      hold_q <= hold_d;
      cnt_q  <= cnt_d;
      obuf_q <= obuf_d;
      pre_q  <= pre_d;
      run_q  <= run_d;
      ien_q  <= ien_d;
      irq_q  <= irq_d;
      ans_q  <= ans_d;
      INTERVAL_IRQ_LINE <= irq_d;
    end
  end

  assign ANS = ans_q;
endmodule
`default_nettype wire

//--- pkg/rtc_defs.svh
// Constants of the interval and elapsed timer, with the rule summary
// Operation
// - Nonzero upper selection field on any transfer gets internal reject.
// - Only matching equipment number is answered; otherwise internal reject.
// - Address word bits 1 to 6 are ignored.
// - Write with direction zero loads holding register and clears counter.
// - Read with direction one returns counter contents.
// - Write with direction one executes every function bit set.
// - Stop plus start, or disable plus enable, gives external reject.
// - Clear controller is done first, then the other functions.
// - Function bits 2 to 5 and 8 to 13 are ignored.
// - Clear zeroes registers and buffer, stops clock, disables interrupt.
// - Stop bit halts counting until start; clear leaves it halted.
// - Start bit clears prescaler and counter, enables counting.
// - Acknowledge bit drops the interrupt response.
// - Disable bit disables interrupts and drops pending response.
// - Enable bit allows interrupt response on compare match.
// - Acknowledge without pending response gives external reject.
// - Read with direction zero gives external reject.
// - External reject leaves all state unchanged.
// - Enabled match raises response, resets counter, keeps counting.
// - Holding value zero means interval of 65536 counts.
// - Holding register changes only on load or clear.
// - Interrupts disabled: no compare, counter wraps freely.
// - Counter restarts after match even without acknowledge.
// - Tick period is one of seven rates from a 20 MHz base.
// - Output buffer keeps last counter value sampled.
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
`define ADDR_DIR_BIT     0
`define ADDR_EQ_LSB      7
`define ADDR_EQ_MSB      10
`define ADDR_W_LSB       11
`define ADDR_W_MSB       15
`define FN_CLEAR_BIT     0
`define FN_ACK_BIT       1
`define FN_STOP_BIT      6
`define FN_START_BIT     7
`define FN_IDIS_BIT      14
`define FN_IEN_BIT       15
`define WORD_ZERO        16'h0000
`define OSC_MHZ          20
`define CLK_MHZ          200
`define TICK_BASE_NS     1000
`define RATE_COUNT       7
`define SEL_ZERO         3'h0
`endif

//--- pkg/rtc_pkg.sv
// Types of the interval and elapsed timer
package rtc_pkg;
  typedef struct packed {
    logic        read;
    logic        write;
    logic [15:0] addr;
    logic [15:0] data;
  } host_req_t;
  typedef struct packed {
    logic        reply;
    logic        ext_reject;
    logic        int_reject;
    logic [15:0] data;
  } host_ans_t;
endpackage

//--- bench/host_channel_model.sv
// Host channel master issuing transfers to the timer
`timescale 1ns/10ps
`default_nettype none
module host_channel_model (
  input  wire logic               REF_CLK,
  input  wire rtc_pkg::host_ans_t ANS,
  output var  rtc_pkg::host_req_t REQ
);
  import rtc_pkg::*;
  initial REQ = '0;
  // Strobe held through the reply edge, then dropped
  task automatic xfer(input logic rd, input logic [15:0] a, d,
                      output host_ans_t r);
    int n;
    @(posedge REF_CLK);
    REQ.addr <= a;
    REQ.data <= d;
    repeat (3) @(posedge REF_CLK);
    REQ.read <= rd;
    REQ.write <= !rd;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (ANS.reply !== 1'b1 && n < 20);
    r = ANS;
    REQ.read <= 1'b0;
    REQ.write <= 1'b0;
    // Released lines flip so a stale word is never mistaken
    REQ.addr <= ~a;
    REQ.data <= ~d;
    repeat (2) @(posedge REF_CLK);
  endtask
endmodule
`default_nettype wire

//--- bench/interval_elapsed_timer_assertions.sv
// Assertions on the timer's channel ports
`timescale 1ns/10ps
`default_nettype none
module interval_elapsed_timer_assertions (
  input wire logic               REF_CLK,
  input wire logic               RST,
  input wire rtc_pkg::host_req_t REQ,
  input wire logic [3:0]         EQUIP_SEL,
  input wire logic [2:0]         RATE_SEL,
  input wire rtc_pkg::host_ans_t ANS,
  input wire logic               INTERVAL_IRQ_LINE
);
  import rtc_pkg::*;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  wire logic go = REQ.read | REQ.write;
  wire logic here = REQ.addr[15:11] == 5'h00 && REQ.addr[10:7] == EQUIP_SEL;
  wire logic fn_ok = ANS.reply & ~ANS.ext_reject & ~ANS.int_reject
                     & REQ.write & REQ.addr[0];
  property p_int_w;
    $rose(go) && REQ.addr[15:11] != 5'h00 |-> ##3 ANS.reply && ANS.int_reject;
  endproperty
  a_int_w: assert property (p_int_w) else $error("no W reject");
  property p_int_eq;
    $rose(go) && REQ.addr[10:7] != EQUIP_SEL |-> ##3 ANS.int_reject;
  endproperty
  a_int_eq: assert property (p_int_eq) else $error("no addr reject");
  property p_rd0;
    $rose(REQ.read) && here && !REQ.addr[0] |-> ##3 ANS.ext_reject;
  endproperty
  a_rd0: assert property (p_rd0) else $error("no read reject");
  property p_both;
    $rose(REQ.write) && here && REQ.addr[0]
      && (&REQ.data[7:6] || &REQ.data[15:14]) |-> ##3 ANS.ext_reject;
  endproperty
  a_both: assert property (p_both) else $error("no pair reject");
  property p_clr;
    fn_ok && REQ.data[0] |-> !INTERVAL_IRQ_LINE [*4];
  endproperty
  a_clr: assert property (p_clr) else $error("clear kept irq");
  property p_ack;
    fn_ok && REQ.data[1] |-> !INTERVAL_IRQ_LINE;
  endproperty
  a_ack: assert property (p_ack) else $error("ack kept irq");
  property p_rej;
    ANS.reply && (ANS.ext_reject || ANS.int_reject) |-> $stable(ANS.data);
  endproperty
  a_rej: assert property (p_rej) else $error("reject moved data");
  property p_fall;
    $fell(INTERVAL_IRQ_LINE) |-> ANS.reply && !ANS.ext_reject;
  endproperty
  a_fall: assert property (p_fall) else $error("irq fell alone");
endmodule
bind interval_elapsed_timer interval_elapsed_timer_assertions chk_i (
  .REF_CLK(REF_CLK), .RST(RST), .REQ(REQ), .EQUIP_SEL(EQUIP_SEL),
  .RATE_SEL(RATE_SEL), .ANS(ANS), .INTERVAL_IRQ_LINE(INTERVAL_IRQ_LINE));
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the interval and elapsed timer
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rtc_pkg::*;
  logic        REF_CLK = 1'b0;
  logic        RST = 1'b1;
  logic        INTERVAL_IRQ_LINE;
  host_req_t   REQ;
  host_ans_t   ANS;
  host_ans_t   r;
  int          num_errors = 0;
  int          checks = 0;
  int          n;
  logic [15:0] v;
  // Read, address, data, expected {ext, int}
  logic [34:0] rows [10] = '{
    {1'h0, 16'h0280, 16'h0003, 2'h0}, {1'h1, 16'h0280, 16'h0000, 2'h2},
    {1'h1, 16'h8281, 16'h0000, 2'h1}, {1'h0, 16'h0301, 16'h0000, 2'h1},
    {1'h0, 16'h0281, 16'h00C0, 2'h2}, {1'h0, 16'h0281, 16'hC000, 2'h2},
    {1'h0, 16'h0281, 16'h0002, 2'h2}, {1'h0, 16'h02FF, 16'h3F3C, 2'h0},
    {1'h1, 16'h02FF, 16'h0000, 2'h0}, {1'h0, 16'h8281, 16'h00C0, 2'h1}};
  interval_elapsed_timer interval_elapsed_timer_i (.REF_CLK(REF_CLK),
    .RST(RST), .REQ(REQ), .EQUIP_SEL(4'h5), .RATE_SEL(3'h0), .ANS(ANS),
    .INTERVAL_IRQ_LINE(INTERVAL_IRQ_LINE));
  host_channel_model host_channel_model_i (.REF_CLK(REF_CLK), .ANS(ANS),
    .REQ(REQ));
  task automatic chk(input string s, input logic [16:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic go(input logic rd, input logic [15:0] a, d);
    host_channel_model_i.xfer(rd, a, d, r);
  endtask
  initial begin
    forever #2.5 REF_CLK = ~REF_CLK;
  end
  // Generous: the longest test waits well under 2000 cycles
  initial begin
    repeat (20000) @(posedge REF_CLK);
    num_errors++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge REF_CLK);
    RST <= 1'b0;
    foreach (rows[i]) begin
      go(rows[i][34], rows[i][33:18], rows[i][17:2]);
      chk("rej", {r.reply, r.ext_reject, r.int_reject},
          {1'b1, rows[i][1:0]});
      if (rows[i][34] && rows[i][1:0] == 2'h0)
        chk("count", r.data, 16'h0000);
    end
    // Second pass without reload shows the holding value kept
    for (int k = 0; k < 2; k++) begin
      go(1'b0, 16'h0281, 16'h8080);
      n = 0;
      while (INTERVAL_IRQ_LINE !== 1'b1 && n < 700) begin
        @(posedge REF_CLK);
        n++;
      end
      chk("ticks", 17'(n > 590 && n < 610), 17'h1);
      go(1'b1, 16'h0281, 16'h0000);
      chk("restart", r.data, 16'h0000);
      go(1'b0, 16'h0281, 16'h0002);
      chk("ack", {r.ext_reject, INTERVAL_IRQ_LINE}, 17'h0);
    end
    go(1'b0, 16'h0281, 16'h0040);
    go(1'b1, 16'h0281, 16'h0000);
    v = r.data;
    repeat (500) @(posedge REF_CLK);
    go(1'b1, 16'h0281, 16'h0000);
    chk("stop", r.data, v);
    go(1'b0, 16'h0281, 16'h4080);
    repeat (1500) @(posedge REF_CLK);
    go(1'b1, 16'h0281, 16'h0000);
    chk("free", {INTERVAL_IRQ_LINE, r.data}, 17'h7);
    go(1'b0, 16'h0281, 16'h8081);
    repeat (800) @(posedge REF_CLK);
    go(1'b1, 16'h0281, 16'h0000);
    chk("clear", {INTERVAL_IRQ_LINE, r.data}, 17'h4);
    RST <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    RST <= 1'b0;
    repeat (300) @(posedge REF_CLK);
    go(1'b1, 16'h0281, 16'h0000);
    chk("mclr", r.data, 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
